// file: rtl/ebm_core_bus_matrix.sv
// Core bus matrix: address decode, port steering, write buffer, debug hooks
// Function
// - Fetches to coupled memory use instruction port
// - Data to coupled memory uses data port
// - Other addresses use system port, except the private peripheral range, which uses PPB port
// - One 4 GB space, four destinations
// - Byte lanes are always little-endian
// - Ports share one address space
// - Different RAM blocks: fetch and data parallel
// - Same RAM block: fetch then data
// - Bit-band aliases always go to system port
// - Debugger reaches all memory independent of core
// - Write buffer holds exactly one write
// - 240 interrupt inputs, 8 priority levels
// - Four data watchpoints plus execution monitoring
// - Six instruction, two literal breakpoint comparators
// - Same comparators can remap addresses
// - No wakeup controller; aggregator supplies wake
`timescale 1ns/1ps
`default_nettype none
module ebm_core_bus_matrix #(
   parameter logic [31:0] RAM_SPLIT = ebm_pkg::RAM_SPLIT,
   parameter int IRQ_N = ebm_pkg::IRQ_N
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire ebm_pkg::ebm_req_t fetch_req,
   input wire ebm_pkg::ebm_req_t data_req,
   input wire ebm_pkg::ebm_req_t dbg_req,
   output logic fetch_done_ff,
   output logic [31:0] fetch_rdata_ff,
   output logic data_done_ff,
   output logic [31:0] data_rdata_ff,
   output logic dbg_done_ff,
   output logic [31:0] dbg_rdata_ff,
   output ebm_pkg::ebm_ahb_addr_t bus_a_ff [ebm_pkg::PORT_N],
   output logic [31:0] bus_wdata_ff [ebm_pkg::PORT_N],
   input wire logic [31:0] bus_rdata [ebm_pkg::PORT_N],
   input wire logic [ebm_pkg::PORT_N-1:0] bus_hready,
   input wire logic [31:0] pch_instr_addr [ebm_pkg::PATCH_INSTR_N],
   input wire logic [ebm_pkg::PATCH_INSTR_N-1:0] pch_instr_en,
   input wire logic [31:0] pch_instr_remap [ebm_pkg::PATCH_INSTR_N],
   input wire logic [ebm_pkg::PATCH_INSTR_N-1:0] pch_instr_remap_en,
   input wire logic [31:0] pch_lit_addr [ebm_pkg::PATCH_LIT_N],
   input wire logic [ebm_pkg::PATCH_LIT_N-1:0] pch_lit_en,
   input wire logic [31:0] pch_lit_remap [ebm_pkg::PATCH_LIT_N],
   input wire logic [ebm_pkg::PATCH_LIT_N-1:0] pch_lit_remap_en,
   input wire logic [31:0] wpt_addr [ebm_pkg::WATCH_N],
   input wire logic [ebm_pkg::WATCH_N-1:0] wpt_en,
   output logic bkpt_ff,
   output logic [ebm_pkg::WATCH_N-1:0] watch_hit_ff,
   output logic [31:0] exec_cnt_ff,
   input wire logic [IRQ_N-1:0] irq_in,
   input wire logic [IRQ_N-1:0] irq_en,
   input wire logic [ebm_pkg::PRIO_W-1:0] irq_prio [IRQ_N],
   output logic irq_pend_ff,
   output logic [ebm_pkg::IRQ_ID_W-1:0] irq_id_ff,
   output logic [ebm_pkg::PRIO_W-1:0] irq_lvl_ff,
   input wire logic agg_wake_in,
   output logic wake_ff
);
   // Decode of the single shared map into a destination port
   function automatic ebm_pkg::ebm_port_t dec_port(input logic [31:0] a, input logic fetch);
      if (a >= ebm_pkg::PPB_LO && a <= ebm_pkg::PPB_HI)
         dec_port = ebm_pkg::PORT_PPB;
      else if ((a >= ebm_pkg::BB0_LO && a <= ebm_pkg::BB0_HI) ||
               (a >= ebm_pkg::BB1_LO && a <= ebm_pkg::BB1_HI))
         dec_port = ebm_pkg::PORT_SYS;
      else if (a < ebm_pkg::CCM_LIMIT)
         dec_port = fetch ? ebm_pkg::PORT_INSTR_CODE_PORT : ebm_pkg::PORT_DATA_CODE_PORT;
      else
         dec_port = ebm_pkg::PORT_SYS;
   endfunction

   // RAM block of a coupled-memory address
   function automatic logic ram_blk(input logic [31:0] a);
      ram_blk = (a >= RAM_SPLIT);
   endfunction

   ebm_pkg::ebm_src_t aph_src_ff [ebm_pkg::PORT_N], dph_src_ff [ebm_pkg::PORT_N];
   logic [31:0] awdata_ff [ebm_pkg::PORT_N];
   ebm_pkg::ebm_req_t wbuf_ff, d_req;
   logic wbuf_vld_ff, wbuf_iss_ff, f_taken_ff, c_taken_ff, g_taken_ff, wake_s1_ff, hold;
   logic [IRQ_N-1:0] irq_s1_ff, irq_s2_ff;
   logic [ebm_pkg::PORT_N-1:0] port_stall;
   logic pi_brk, pi_remap, pl_brk, pl_remap;
   logic [31:0] pi_addr, pl_addr, f_addr, rd_f, rd_c, rd_g;
   logic [ebm_pkg::WATCH_N-1:0] w_hit;
   ebm_pkg::ebm_port_t f_port, d_port;
   ebm_pkg::ebm_src_t d_src;
   logic f_want, g_want, c_rd, c_post, conflict, iss_f, iss_d, iss_c;
   logic cmp_f, cmp_c, cmp_g, cmp_w, best_vld;
   logic [ebm_pkg::IRQ_ID_W-1:0] best_id;
   logic [ebm_pkg::PRIO_W-1:0] best_lvl;

   // Instruction and literal patch comparators, then data watchpoints
   ebm_match #(.N(ebm_pkg::PATCH_INSTR_N)) u_pch_instr (
      .addr(fetch_req.addr), .cmp_addr(pch_instr_addr), .cmp_en(pch_instr_en),
      .remap_addr(pch_instr_remap), .remap_en(pch_instr_remap_en),
      .hit(), .brk(pi_brk), .remap_vld(pi_remap), .remap_out(pi_addr));
   ebm_match #(.N(ebm_pkg::PATCH_LIT_N)) u_pch_lit (
      .addr(data_req.addr), .cmp_addr(pch_lit_addr), .cmp_en(pch_lit_en),
      .remap_addr(pch_lit_remap), .remap_en(pch_lit_remap_en),
      .hit(), .brk(pl_brk), .remap_vld(pl_remap), .remap_out(pl_addr));
   ebm_match #(.N(ebm_pkg::WATCH_N)) u_watch (
      .addr(data_req.addr), .cmp_addr(wpt_addr), .cmp_en(wpt_en),
      .remap_addr(wpt_addr), .remap_en('0),
      .hit(w_hit), .brk(), .remap_vld(), .remap_out());

   // Any port whose data phase is waiting freezes issue and the phase registers of all four ports
   genvar g;
   generate
      for (g = 0; g < ebm_pkg::PORT_N; g++) begin : g_stall
         assign port_stall[g] = (dph_src_ff[g] != ebm_pkg::SRC_NONE) && !bus_hready[g];
      end
   endgenerate
   assign hold = |port_stall;

   // Candidate selection, same-cycle decode and conflict check
   always_comb begin
      f_addr = pi_remap ? pi_addr : fetch_req.addr;
      f_port = dec_port(f_addr, 1'b1);
      f_want = fetch_req.vld && !f_taken_ff && !fetch_done_ff;
      g_want = dbg_req.vld && !g_taken_ff && !dbg_done_ff;
      c_rd = data_req.vld && !data_req.write && !c_taken_ff && !data_done_ff && !wbuf_vld_ff;
      c_post = data_req.vld && data_req.write && !c_taken_ff && !data_done_ff &&
               !wbuf_vld_ff;
      d_src = ebm_pkg::SRC_NONE;
      d_req = ebm_pkg::EMPTY_REQ;
      if (g_want) begin
         d_src = ebm_pkg::SRC_DBG;
         d_req = dbg_req;
      end else if (wbuf_vld_ff && !wbuf_iss_ff) begin
         d_src = ebm_pkg::SRC_WBUF;
         d_req = wbuf_ff;
      end else if (c_rd) begin
         d_src = ebm_pkg::SRC_CORE;
         d_req = data_req;
         d_req.addr = pl_remap ? pl_addr : data_req.addr;
      end
      d_port = dec_port(d_req.addr, 1'b0);
      conflict = f_want && (d_src != ebm_pkg::SRC_NONE) &&
                 ((f_port == d_port) ||
                  (f_port == ebm_pkg::PORT_INSTR_CODE_PORT && d_port == ebm_pkg::PORT_DATA_CODE_PORT &&
                   ram_blk(f_addr) == ram_blk(d_req.addr)));
      iss_f = f_want && !hold;
      iss_d = (d_src != ebm_pkg::SRC_NONE) && !hold && !conflict;
      iss_c = iss_d && (d_src == ebm_pkg::SRC_CORE);
   end

   // Data phase completions returned to their owners
   always_comb begin
      cmp_f = 1'b0;
      cmp_c = 1'b0;
      cmp_g = 1'b0;
      cmp_w = 1'b0;
      rd_f = '0;
      rd_c = '0;
      rd_g = '0;
      for (int i = 0; i < ebm_pkg::PORT_N; i++) begin
         if (!hold && dph_src_ff[i] == ebm_pkg::SRC_FETCH) begin
            cmp_f = 1'b1;
            rd_f = bus_rdata[i];
         end
         if (!hold && dph_src_ff[i] == ebm_pkg::SRC_CORE) begin
            cmp_c = 1'b1;
            rd_c = bus_rdata[i] >> {data_req.addr[1:0], 3'b000};
         end
         if (!hold && dph_src_ff[i] == ebm_pkg::SRC_DBG) begin
            cmp_g = 1'b1;
            rd_g = bus_rdata[i] >> {dbg_req.addr[1:0], 3'b000};
         end
         if (!hold && dph_src_ff[i] == ebm_pkg::SRC_WBUF)
            cmp_w = 1'b1;
      end
   end

   // Per-port address and data phase registers, request address on its decoded port, idle address on the others
   generate
      for (g = 0; g < ebm_pkg::PORT_N; g++) begin : g_port
         localparam ebm_pkg::ebm_port_t PID = ebm_pkg::ebm_port_t'(2'(g));
         always_ff @(posedge clock or negedge rst_b) begin
            if (!rst_b) begin
               bus_a_ff[g] <= ebm_pkg::IDLE_ADDR;
               bus_wdata_ff[g] <= '0;
               awdata_ff[g] <= '0;
               aph_src_ff[g] <= ebm_pkg::SRC_NONE;
               dph_src_ff[g] <= ebm_pkg::SRC_NONE;
            end else if (!hold) begin
               dph_src_ff[g] <= aph_src_ff[g];
               bus_wdata_ff[g] <= awdata_ff[g];
               if (iss_f && f_port == PID) begin
                  bus_a_ff[g] <= '{haddr: f_addr, htrans: ebm_pkg::HTRANS_NONSEQ,
                                   hwrite: 1'b0, hsize: ebm_pkg::HSIZE_WORD};
                  aph_src_ff[g] <= ebm_pkg::SRC_FETCH;
                  awdata_ff[g] <= '0;
               end else if (iss_d && d_port == PID) begin
                  bus_a_ff[g] <= '{haddr: d_req.addr, htrans: ebm_pkg::HTRANS_NONSEQ,
                                   hwrite: d_req.write, hsize: d_req.size};
                  aph_src_ff[g] <= d_src;
                  awdata_ff[g] <= d_req.wdata << {d_req.addr[1:0], 3'b000};
               end else begin
                  bus_a_ff[g] <= ebm_pkg::IDLE_ADDR;
                  aph_src_ff[g] <= ebm_pkg::SRC_NONE;
                  awdata_ff[g] <= '0;
               end
            end
         end
      end
   endgenerate

   // Outstanding flags; cleared the cycle after the done pulse
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         f_taken_ff <= 1'b0;
         c_taken_ff <= 1'b0;
         g_taken_ff <= 1'b0;
      end else begin
         f_taken_ff <= iss_f || (f_taken_ff && !fetch_done_ff);
         c_taken_ff <= iss_c || c_post || (c_taken_ff && !data_done_ff);
         g_taken_ff <= (iss_d && d_src == ebm_pkg::SRC_DBG) || (g_taken_ff && !dbg_done_ff);
      end
   end

   // Single-entry posted write buffer
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         wbuf_ff <= ebm_pkg::EMPTY_REQ;
         wbuf_vld_ff <= 1'b0;
         wbuf_iss_ff <= 1'b0;
      end else begin
         if (c_post)
            wbuf_ff <= data_req;
         wbuf_vld_ff <= c_post || (wbuf_vld_ff && !cmp_w);
         wbuf_iss_ff <= (iss_d && d_src == ebm_pkg::SRC_WBUF) || (wbuf_iss_ff && !cmp_w);
      end
   end

   // Done pulses and read data to core and debugger
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         fetch_done_ff <= 1'b0;
         data_done_ff <= 1'b0;
         dbg_done_ff <= 1'b0;
         fetch_rdata_ff <= '0;
         data_rdata_ff <= '0;
         dbg_rdata_ff <= '0;
      end else begin
         fetch_done_ff <= cmp_f;
         data_done_ff <= c_post || cmp_c;
         dbg_done_ff <= cmp_g;
         if (cmp_f)
            fetch_rdata_ff <= rd_f;
         if (cmp_c)
            data_rdata_ff <= rd_c;
         if (cmp_g)
            dbg_rdata_ff <= rd_g;
      end
   end

   // Breakpoints, watchpoint hits and executed-fetch counter
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         bkpt_ff <= 1'b0;
         watch_hit_ff <= '0;
         exec_cnt_ff <= '0;
      end else begin
         bkpt_ff <= (iss_f && pi_brk) || (iss_c && pl_brk);
         watch_hit_ff <= (iss_c || c_post) ? w_hit : '0;
         if (cmp_f)
            exec_cnt_ff <= exec_cnt_ff + ebm_pkg::EXEC_STEP;
      end
   end

   // Highest pending interrupt: lowest level number, then lowest input
   always_comb begin
      best_vld = 1'b0;
      best_id = '0;
      best_lvl = '1;
      for (int i = IRQ_N - 1; i >= 0; i--) begin
         if (irq_s2_ff[i] && irq_en[i] && (!best_vld || irq_prio[i] <= best_lvl)) begin
            best_vld = 1'b1;
            best_id = ebm_pkg::IRQ_ID_W'(i);
            best_lvl = irq_prio[i];
         end
      end
   end

   // Interrupt pins and aggregator wake pass two flops first
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         irq_s1_ff <= '0;
         irq_s2_ff <= '0;
         irq_pend_ff <= 1'b0;
         irq_id_ff <= '0;
         irq_lvl_ff <= '0;
         wake_s1_ff <= 1'b0;
         wake_ff <= 1'b0;
      end else begin
         irq_s1_ff <= irq_in;
         irq_s2_ff <= irq_s1_ff;
         irq_pend_ff <= best_vld;
         irq_id_ff <= best_id;
         irq_lvl_ff <= best_vld ? best_lvl : '0;
         wake_s1_ff <= agg_wake_in;
         wake_ff <= wake_s1_ff;
      end
   end

   // Checks on routing, ordering and side units
   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!rst_b);

   fetch_instr_code_port_a: assert property (
      (iss_f && f_addr < ebm_pkg::CCM_LIMIT) |=>
      bus_a_ff[ebm_pkg::PORT_INSTR_CODE_PORT].htrans == ebm_pkg::HTRANS_NONSEQ &&
      bus_a_ff[ebm_pkg::PORT_INSTR_CODE_PORT].haddr == $past(f_addr))
      else $error("fetch to coupled memory missed the instruction port");
   data_data_code_port_a: assert property (
      (iss_d && d_req.addr < ebm_pkg::CCM_LIMIT) |=>
      bus_a_ff[ebm_pkg::PORT_DATA_CODE_PORT].htrans == ebm_pkg::HTRANS_NONSEQ)
      else $error("data to coupled memory missed the data port");
   sys_range_a: assert property (
      bus_a_ff[ebm_pkg::PORT_SYS].htrans == ebm_pkg::HTRANS_NONSEQ |->
      bus_a_ff[ebm_pkg::PORT_SYS].haddr >= ebm_pkg::CCM_LIMIT &&
      !(bus_a_ff[ebm_pkg::PORT_SYS].haddr inside {[ebm_pkg::PPB_LO:ebm_pkg::PPB_HI]}))
      else $error("system port carried a coupled or private address");
   bitband_sys_a: assert property (
      (iss_d && d_req.addr inside {[ebm_pkg::BB0_LO:ebm_pkg::BB0_HI],
                                   [ebm_pkg::BB1_LO:ebm_pkg::BB1_HI]}) |=>
      aph_src_ff[ebm_pkg::PORT_SYS] == $past(d_src))
      else $error("bit-band access not on the system port");
   same_addr_a: assert property (
      iss_d |=> bus_a_ff[$past(d_port)].haddr == $past(d_req.addr))
      else $error("port address differs from the request address");
   parallel_issue_a: assert property (
      (iss_f && iss_d) |=> aph_src_ff[$past(f_port)] == ebm_pkg::SRC_FETCH &&
      aph_src_ff[$past(d_port)] == $past(d_src))
      else $error("fetch and data not issued together");
   serial_order_a: assert property (
      (conflict && !hold) |=> aph_src_ff[$past(f_port)] == ebm_pkg::SRC_FETCH &&
      aph_src_ff[$past(d_port)] != $past(d_src))
      else $error("same-block fetch and data not serialized");
   dbg_first_a: assert property (
      (g_want && !hold && !conflict) |=> aph_src_ff[$past(d_port)] == ebm_pkg::SRC_DBG)
      else $error("debugger access not issued");
   wbuf_one_a: assert property (
      c_post |=> wbuf_vld_ff && data_done_ff ##1 !c_post)
      else $error("write buffer entry not held");
   irq_idle_a: assert property (
      (irq_s2_ff == '0) |=> !irq_pend_ff)
      else $error("interrupt pending with no input");
   watch_cause_a: assert property (
      (watch_hit_ff != '0) |-> $past(iss_c || c_post))
      else $error("watchpoint hit without a data access");
   patch_remap_a: assert property (
      (iss_f && pi_remap) |=> bus_a_ff[$past(f_port)].haddr == $past(pi_addr))
      else $error("fetch not remapped by the patch unit");
   wake_pass_a: assert property (
      wake_ff == $past(agg_wake_in, 2))
      else $error("wake does not follow the aggregator");

   both_ports_c: cover property (iss_f && iss_d);
   conflict_c: cover property (conflict && !hold ##1 iss_d);
   posted_c: cover property (c_post ##[1:4] cmp_w);
   debug_c: cover property (iss_d && d_src == ebm_pkg::SRC_DBG);
endmodule // ebm_core_bus_matrix
`default_nettype wire

// file: rtl/ebm_pkg.sv
// Shared constants, address map and carrier types of the core bus matrix
package ebm_pkg;
   // Widths and counts
   localparam int ADDR_W = 32;
   localparam int DATA_W = 32;
   localparam int PORT_N = 4;
   localparam int IRQ_N = 240;
   localparam int IRQ_ID_W = 8;
   localparam int PRIO_W = 3;
   localparam int WATCH_N = 4;
   localparam int PATCH_INSTR_N = 6;
   localparam int PATCH_LIT_N = 2;
   localparam int CMP_LSB = 2;
   localparam int LANE_SHIFT_W = 5;
   // Unified address map: one space shared by every port
   localparam logic [31:0] CCM_LIMIT = 32'h2000_0000;
   localparam logic [31:0] RAM_SPLIT = 32'h1000_0000;
   localparam logic [31:0] BB0_LO = 32'h2200_0000;
   localparam logic [31:0] BB0_HI = 32'h23ff_ffff;
   localparam logic [31:0] BB1_LO = 32'h4200_0000;
   localparam logic [31:0] BB1_HI = 32'h43ff_ffff;
   localparam logic [31:0] PPB_LO = 32'he000_0000;
   localparam logic [31:0] PPB_HI = 32'he00f_ffff;
   // Bus encodings
   localparam logic [1:0] HTRANS_IDLE = 2'h0;
   localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
   localparam logic [2:0] HSIZE_WORD = 3'h2;
   localparam logic [31:0] EXEC_STEP = 32'h0000_0001;

   // Destination ports
   typedef enum logic [1:0] {
      PORT_INSTR_CODE_PORT = 2'b00,
      PORT_DATA_CODE_PORT = 2'b01,
      PORT_SYS = 2'b10,
      PORT_PPB = 2'b11
   } ebm_port_t;

   // Owner of an access on a port
   typedef enum logic [2:0] {
      SRC_NONE = 3'b000,
      SRC_FETCH = 3'b001,
      SRC_CORE = 3'b010,
      SRC_DBG = 3'b011,
      SRC_WBUF = 3'b100
   } ebm_src_t;

   // Address phase of one master port
   typedef struct packed {
      logic [31:0] haddr;
      logic [1:0] htrans;
      logic hwrite;
      logic [2:0] hsize;
   } ebm_ahb_addr_t;

   // Request from the core or the debugger, held until its done pulse
   typedef struct packed {
      logic vld;
      logic [31:0] addr;
      logic write;
      logic [2:0] size;
      logic [31:0] wdata;
   } ebm_req_t;

   localparam ebm_ahb_addr_t IDLE_ADDR = '{haddr: 32'h0000_0000, htrans: HTRANS_IDLE,
                                          hwrite: 1'b0, hsize: HSIZE_WORD};
   localparam ebm_req_t EMPTY_REQ = '{vld: 1'b0, addr: 32'h0000_0000, write: 1'b0,
                                      size: HSIZE_WORD, wdata: 32'h0000_0000};
endpackage

// file: rtl/ebm_match.sv
// Bank of word-address comparators with optional address substitution
`timescale 1ns/1ps
`default_nettype none
module ebm_match #(
   parameter int N = 4
) (
   input wire logic [31:0] addr,
   input wire logic [31:0] cmp_addr [N],
   input wire logic [N-1:0] cmp_en,
   input wire logic [31:0] remap_addr [N],
   input wire logic [N-1:0] remap_en,
   output logic [N-1:0] hit,
   output logic brk,
   output logic remap_vld,
   output logic [31:0] remap_out
);
   // One comparator per slot on the word address
   genvar g;
   generate
      for (g = 0; g < N; g++) begin : g_cmp
         assign hit[g] = cmp_en[g] &&
                         (addr[31:ebm_pkg::CMP_LSB] == cmp_addr[g][31:ebm_pkg::CMP_LSB]);
      end
   endgenerate

   // Hits without substitution break; the lowest substituting slot wins
   always_comb begin
      brk = |(hit & ~remap_en);
      remap_vld = 1'b0;
      remap_out = addr;
      for (int i = N - 1; i >= 0; i--) begin
         if (hit[i] && remap_en[i]) begin
            remap_vld = 1'b1;
            remap_out = {remap_addr[i][31:ebm_pkg::CMP_LSB], addr[ebm_pkg::CMP_LSB-1:0]};
         end
      end
   end
endmodule // ebm_match
`default_nettype wire

// file: verif/ebm_slave_model.sv
// Slave models answering on the four bus ports of the matrix
`timescale 1ns/1ps
`default_nettype none
module ebm_slave_model #(
   parameter logic [31:0] KEY = 32'h5a3c_0000
) (
   input wire logic clock,
   input wire logic rst_b,
   input wire logic slow,
   input wire ebm_pkg::ebm_ahb_addr_t bus_a [ebm_pkg::PORT_N],
   output logic [31:0] rdata [ebm_pkg::PORT_N],
   output logic [ebm_pkg::PORT_N-1:0] hready
);
   logic [3:0] dph_ff, wait_ff;
   logic [31:0] addr_ff [4];
   logic [31:0] last_ff [4];
   // Accept address phases only while every port is ready
   always_ff @(posedge clock or negedge rst_b) begin
      if (!rst_b) begin
         dph_ff <= '0;
         wait_ff <= '0;
         addr_ff <= '{default: '0};
         last_ff <= '{default: '0};
      end else if (&hready) begin
         wait_ff <= '0;
         for (int p = 0; p < 4; p++) begin
            dph_ff[p] <= bus_a[p].htrans == ebm_pkg::HTRANS_NONSEQ;
            addr_ff[p] <= bus_a[p].haddr;
            last_ff[p] <= rdata[p];
         end
      end else begin
         wait_ff <= dph_ff;
      end
   end
   // Slow mode adds one wait cycle; idle data lines toggle every cycle in which all ports are ready
   always_comb begin
      for (int p = 0; p < 4; p++) begin
         hready[p] = !(slow && dph_ff[p] && !wait_ff[p]);
         rdata[p] = dph_ff[p] ? addr_ff[p] ^ KEY : ~last_ff[p];
      end
   end
endmodule // ebm_slave_model
`default_nettype wire

// file: verif/testbench.sv
// Self-checking bench for the core bus matrix against four slave models
`timescale 1ns/1ps
`default_nettype none
module testbench;
   localparam logic [31:0] KEY = 32'h5a3c_0000;
   localparam logic [2:0] WORD = ebm_pkg::HSIZE_WORD;
   logic clock, rst_b, slow, agg_wake_in, bkpt_ff, irq_pend_ff, wake_ff, wr_dph, bk_seen;
   logic fetch_done_ff, data_done_ff, dbg_done_ff;
   ebm_pkg::ebm_req_t fetch_req, data_req, dbg_req, e;
   logic [31:0] fetch_rdata_ff, data_rdata_ff, dbg_rdata_ff, exec_cnt_ff;
   logic [31:0] seen_addr, seen_wdata;
   ebm_pkg::ebm_ahb_addr_t bus_a_ff [4];
   logic [31:0] bus_wdata_ff [4];
   logic [31:0] bus_rdata [4];
   logic [3:0] bus_hready, wpt_en, watch_hit_ff, wh_seen;
   logic [31:0] pch_instr_addr [6];
   logic [31:0] pch_instr_remap [6];
   logic [5:0] pch_instr_en, pch_instr_remap_en;
   logic [31:0] pch_lit_addr [2];
   logic [31:0] pch_lit_remap [2];
   logic [1:0] pch_lit_en, pch_lit_remap_en;
   logic [31:0] wpt_addr [4];
   logic [239:0] irq_in, irq_en;
   logic [2:0] irq_prio [240];
   logic [7:0] irq_id_ff;
   logic [2:0] irq_lvl_ff;
   int bad_count, compares, cyc, seen_port, l0, l1, l2;
   ebm_core_bus_matrix u_dut (.clock, .rst_b, .fetch_req, .data_req, .dbg_req, .fetch_done_ff,
      .fetch_rdata_ff, .data_done_ff, .data_rdata_ff, .dbg_done_ff, .dbg_rdata_ff, .bus_a_ff,
      .bus_wdata_ff, .bus_rdata, .bus_hready, .pch_instr_addr, .pch_instr_en, .pch_instr_remap,
      .pch_instr_remap_en, .pch_lit_addr, .pch_lit_en, .pch_lit_remap, .pch_lit_remap_en,
      .wpt_addr, .wpt_en, .bkpt_ff, .watch_hit_ff, .exec_cnt_ff, .irq_in, .irq_en, .irq_prio,
      .irq_pend_ff, .irq_id_ff, .irq_lvl_ff, .agg_wake_in, .wake_ff);
   ebm_slave_model #(.KEY(KEY)) u_slave (.clock, .rst_b, .slow, .bus_a(bus_a_ff),
      .rdata(bus_rdata), .hready(bus_hready));
   // Clock at 25 MHz
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   // Bus monitor, sticky debug flags and run-time ceiling
   always @(posedge clock) begin
      if (wr_dph)
         seen_wdata = bus_wdata_ff[seen_port];
      wr_dph = 1'b0;
      for (int p = 0; p < 4; p++)
         if (bus_a_ff[p].htrans === ebm_pkg::HTRANS_NONSEQ) begin
            seen_port = p;
            seen_addr = bus_a_ff[p].haddr;
            wr_dph = bus_a_ff[p].hwrite;
         end
      bk_seen = bk_seen | bkpt_ff;
      wh_seen = wh_seen | watch_hit_ff;
      cyc++;
      if (cyc == 2000) begin
         bad_count++;
         tally_and_finish;
      end
   end
   task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         bad_count++;
         $display("Error %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic tally_and_finish;
      $display("Checks %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   function automatic ebm_pkg::ebm_req_t mk(input logic [31:0] a, input int w,
         input logic [2:0] s, input logic [31:0] d);
      mk = '{vld: 1'b1, addr: a, write: (w != 0), size: s, wdata: d};
   endfunction
   // Raise requests together, drop each at its done pulse, note latencies
   task automatic run(input ebm_pkg::ebm_req_t f, input ebm_pkg::ebm_req_t d,
         input ebm_pkg::ebm_req_t g, output int lf, output int ld, output int lg);
      lf = 0;
      ld = 0;
      lg = 0;
      @(negedge clock);
      seen_port = -1;
      bk_seen = 1'b0;
      wh_seen = 4'h0;
      fetch_req = f;
      data_req = d;
      dbg_req = g;
      for (int n = 1; n < 20 && (fetch_req.vld || data_req.vld || dbg_req.vld); n++) begin
         @(negedge clock);
         if (fetch_done_ff === 1'b1 && fetch_req.vld) begin
            lf = n;
            fetch_req = e;
         end
         if (data_done_ff === 1'b1 && data_req.vld) begin
            ld = n;
            data_req = e;
         end
         if (dbg_done_ff === 1'b1 && dbg_req.vld) begin
            lg = n;
            dbg_req = e;
         end
      end
   endtask
   // One word read by fetch, core or debugger, judged for port, data and delay
   task automatic rt(input int who, input logic [31:0] a, input int port);
      int l [3];
      run(who == 0 ? mk(a, 0, WORD, 0) : e, who == 1 ? mk(a, 0, WORD, 0) : e,
         who == 2 ? mk(a, 0, WORD, 0) : e, l[0], l[1], l[2]);
      chk("port", 32'(port), 32'(seen_port));
      chk("haddr", a, seen_addr);
      chk("rdata", a ^ KEY, who == 0 ? fetch_rdata_ff : who == 1 ? data_rdata_ff : dbg_rdata_ff);
      chk("latency", 32'd3, 32'(l[who]));
   endtask
   task automatic t_lanes;
      run(e, mk(32'h1000_0202, 0, 3'h0, 0), e, l0, l1, l2);
      chk("byte rd", 32'(8'((32'h1000_0202 ^ KEY) >> 16)), 32'(data_rdata_ff[7:0]));
      run(e, mk(32'h4000_0003, 1, 3'h0, 32'h5a), e, l0, l1, l2);
      chk("post lat", 32'd1, 32'(l1));
      repeat (3) @(negedge clock);
      chk("wr port", 32'd2, 32'(seen_port));
      chk("wr lane", 32'h5a, 32'(seen_wdata[31:24]));
      run(e, e, mk(32'h6000_0001, 1, 3'h0, 32'h77), l0, l1, l2);
      chk("dbg wr lat", 32'd3, 32'(l2));
      chk("dbg lane", 32'h77, 32'(seen_wdata[15:8]));
      slow = 1'b1;
      run(e, mk(32'h1000_0010, 1, WORD, 1), e, l0, l1, l2);
      run(e, mk(32'h1000_0014, 1, WORD, 2), e, l0, l1, l2);
      chk("slot full", 32'd1, 32'(l1 > 1));
      repeat (4) @(negedge clock);
      run(mk(32'h0000_0104, 0, WORD, 0), e, e, l0, l1, l2);
      chk("stall lat", 32'd4, 32'(l0));
      slow = 1'b0;
   endtask
   task automatic t_par;
      run(mk(32'h0000_0100, 0, WORD, 0), mk(32'h1000_0100, 0, WORD, 0), e, l0, l1, l2);
      chk("par d", 32'(l0), 32'(l1));
      run(mk(32'h0000_0100, 0, WORD, 0), mk(32'h0000_0200, 0, WORD, 0), e, l0, l1, l2);
      chk("ser d", 32'(l0 + 1), 32'(l1));
   endtask
   task automatic t_patch;
      logic [31:0] cnt;
      cnt = exec_cnt_ff;
      pch_instr_addr[5] = 32'h0000_0400;
      pch_instr_en[5] = 1'b1;
      run(mk(32'h0000_0400, 0, WORD, 0), e, e, l0, l1, l2);
      @(negedge clock);
      chk("bkpt", 32'd1, 32'(bk_seen));
      chk("exec", cnt + 32'd1, exec_cnt_ff);
      pch_instr_addr[0] = 32'h0000_0500;
      pch_instr_remap[0] = 32'h0000_0800;
      pch_instr_en[0] = 1'b1;
      pch_instr_remap_en[0] = 1'b1;
      run(mk(32'h0000_0500, 0, WORD, 0), e, e, l0, l1, l2);
      chk("remap", 32'h0000_0800, seen_addr);
      chk("no bkpt", 32'd0, 32'(bk_seen));
      pch_lit_addr[1] = 32'h1000_0600;
      pch_lit_en[1] = 1'b1;
      wpt_addr[3] = 32'h1000_0600;
      wpt_en[3] = 1'b1;
      run(e, mk(32'h1000_0600, 0, WORD, 0), e, l0, l1, l2);
      chk("lit bkpt", 32'd1, 32'(bk_seen));
      chk("watch", 32'h8, 32'(wh_seen));
   endtask
   task automatic t_irq;
      irq_prio[239] = 3'h0;
      irq_prio[3] = 3'h5;
      irq_in[239] = 1'b1;
      irq_in[3] = 1'b1;
      for (int n = 0; n < 10 && irq_id_ff !== 8'hef; n++)
         @(negedge clock);
      chk("irq top", 32'h0000_0f78, 32'({irq_pend_ff, irq_id_ff, irq_lvl_ff}));
      irq_prio[3] = 3'h0;
      for (int n = 0; n < 10 && irq_id_ff !== 8'h03; n++)
         @(negedge clock);
      chk("irq tie", 32'h3, 32'(irq_id_ff));
      irq_en[3] = 1'b0;
      for (int n = 0; n < 10 && irq_id_ff !== 8'hef; n++)
         @(negedge clock);
      chk("irq mask", 32'hef, 32'(irq_id_ff));
   endtask
   // Reset, then each scenario in turn
   initial begin
      {rst_b, slow, agg_wake_in, wr_dph, bk_seen, wh_seen} = '0;
      {bad_count, compares, cyc} = '0;
      e = ebm_pkg::EMPTY_REQ;
      {fetch_req, data_req, dbg_req} = {e, e, e};
      {irq_in, irq_en} = {240'h0, {240{1'b1}}};
      irq_prio = '{default: 3'h7};
      {pch_instr_en, pch_instr_remap_en, pch_lit_en, pch_lit_remap_en, wpt_en} = '0;
      pch_instr_addr = '{default: '0};
      pch_instr_remap = '{default: '0};
      pch_lit_addr = '{default: '0};
      pch_lit_remap = '{default: 32'h0000_0900};
      wpt_addr = '{default: '0};
      repeat (10) @(negedge clock);
      rst_b = 1'b1;
      rt(0, 32'h0000_0100, 0);
      rt(1, 32'h1000_0200, 1);
      rt(1, 32'h4000_0000, 2);
      rt(1, 32'h2200_0004, 2);
      rt(1, 32'h43ff_fffc, 2);
      rt(1, 32'he000_e000, 3);
      rt(2, 32'h0000_0100, 1);
      rt(2, 32'h6000_0000, 2);
      t_lanes;
      t_par;
      t_patch;
      t_irq;
      agg_wake_in = 1'b1;
      @(negedge clock);
      chk("wake 1", 32'h0, 32'(wake_ff));
      @(negedge clock);
      chk("wake 2", 32'h1, 32'(wake_ff));
      tally_and_finish;
   end
endmodule // testbench
`default_nettype wire
